// >>> logic/standalone_mode_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "sa_seq_consts.vh"
// Behaviour
// R1 - power-on selects erase-program-verify mode
// R2 - mode key steps modes in fixed cycle
// R3 - one lamp per selected mode
// R4 - enter key starts selected command
// R5 - running command's lamp blinks
// R6 - commands use stored host configuration
// R7 - load mode lights only load lamp
// R8 - host command also starts rom download
// R9 - access lamp lit during rom access
// R10 - signature check before download, error abort
// R11 - failure shown only by error lamp
// R12 - 32-pin byte-wide rom, top lines optional
// R13 - interface switch latched once at start-up
// R14 - parallel link compatibility or ecp mode
// R15 - serial or parallel host link only
// R16 - rom read: address, select, wait, capture
module standalone_mode_sequencer #(
  parameter integer BLINK_CYC = `BLINK_CYC,
  parameter integer DEBOUNCE_CYC = `DEBOUNCE_CYC,
  parameter [7:0] SIG_MAKER = 8'h5a, // arbitrary
  parameter [7:0] SIG_PART_256K = 8'h11, // arbitrary
  parameter [7:0] SIG_PART_512K = 8'h12, // arbitrary
  parameter [7:0] SIG_PART_1M = 8'h13, // arbitrary
  parameter [19:0] LOAD_LEN = 20'h00100
) (
  input wire MCLK,
  input wire SRST,
  input wire MODE_KEY_N,
  input wire ENTER_KEY_N,
  input wire IF_SELECT_SW,
  input wire ECP_MODE_SW,
  input wire HOST_LOAD_REQ,
  input wire CONFIG_VALID,
  input wire TARGET_DONE,
  input wire TARGET_FAIL,
  input wire LOAD_ACK,
  input wire [7:0] ROM_DATA,
  output reg [4:0] MODE_LAMP,
  output reg ACCESS_LAMP,
  output reg ERROR_LAMP,
  output reg [4:0] TARGET_CMD,
  output reg IF_PARALLEL_SEL,
  output reg PAR_ECP_SEL,
  output reg [19:0] ROM_ADDR,
  output reg ROM_CE_N,
  output reg ROM_OE_N,
  output reg [7:0] LOAD_DATA,
  output reg LOAD_VALID,
  output reg [1:0] ROM_SIZE,
  output reg BUSY
);
  // =====================================
  // states
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_RUN = 6'h02;
  localparam [5:0] ST_SIG = 6'h04;
  localparam [5:0] ST_COPY = 6'h08;
  localparam [5:0] ST_PUSH = 6'h10;
  localparam [5:0] ST_WAIT = 6'h20;

  function [4:0] next_mode;
    input [4:0] m;
    begin
      case (m)
        `MODE_EPV: next_mode = `MODE_ERASE;
        `MODE_ERASE: next_mode = `MODE_PROG;
        `MODE_PROG: next_mode = `MODE_VERIFY;
        `MODE_VERIFY: next_mode = `MODE_LOAD;
        default: next_mode = `MODE_EPV;
      endcase
    end
  endfunction

  // =====================================
  // input synchronisers
  wire mode_press;
  wire enter_press;
  reg [6:0] s1_ff;
  reg [6:0] s2_ff;
  reg [7:0] d1_ff;
  reg [7:0] d2_ff;
  // no reset: stages must hold true pin levels when reset ends
  always @(posedge MCLK) begin
    s1_ff <= {IF_SELECT_SW, ECP_MODE_SW, HOST_LOAD_REQ, CONFIG_VALID, TARGET_DONE,
              TARGET_FAIL, LOAD_ACK};
    s2_ff <= s1_ff;
    d1_ff <= ROM_DATA;
    d2_ff <= d1_ff;
  end
  wire if_sw = s2_ff[6];
  wire ecp_sw = s2_ff[5];
  wire host_req = s2_ff[4];
  wire cfg_ok = s2_ff[3];
  wire tgt_done = s2_ff[2];
  wire tgt_fail = s2_ff[1];
  wire ld_ack = s2_ff[0];

  key_filter #(.STABLE_CYC(DEBOUNCE_CYC)) u_mode_key (
    .clk(MCLK),
    .srst(SRST),
    .key_n(MODE_KEY_N),
    .press_ff(mode_press)
  );
  key_filter #(.STABLE_CYC(DEBOUNCE_CYC)) u_enter_key (
    .clk(MCLK),
    .srst(SRST),
    .key_n(ENTER_KEY_N),
    .press_ff(enter_press)
  );

  // =====================================
  // rom reader
  reg rd_start_ff;
  reg [19:0] rd_addr_ff;
  wire [19:0] rd_rom_addr;
  wire rd_ce_n;
  wire rd_oe_n;
  wire [7:0] rd_data;
  wire rd_done;
  rom_reader #(.WAIT_CYC(`ROM_ACCESS_CYC)) u_rom (
    .clk(MCLK),
    .srst(SRST),
    .start(rd_start_ff),
    .addr(rd_addr_ff),
    .rom_data_in(d2_ff),
    .rom_addr_ff(rd_rom_addr),
    .rom_ce_n_ff(rd_ce_n),
    .rom_oe_n_ff(rd_oe_n),
    .data_ff(rd_data),
    .done_ff(rd_done)
  );

  // =====================================
  // sequencer
  reg [5:0] st_ff;
  reg [4:0] mode_ff;
  reg [4:0] run_ff;
  reg err_ff;
  reg latched_ff;
  reg host_req_d_ff;
  reg sig_idx_ff;
  reg [7:0] maker_ff;
  reg [19:0] cnt_ff;
  reg [19:0] len_ff;
  reg [31:0] blink_cnt_ff;
  reg blink_ff;
  wire host_start = host_req & ~host_req_d_ff;

  always @(posedge MCLK) begin
    if (SRST) begin
      st_ff <= ST_IDLE;
      mode_ff <= `MODE_EPV; // R1
      run_ff <= 5'h0;
      err_ff <= 1'b0;
      latched_ff <= 1'b0;
      IF_PARALLEL_SEL <= `IF_SERIAL;
      PAR_ECP_SEL <= 1'b0;
      host_req_d_ff <= 1'b0;
      sig_idx_ff <= 1'b0;
      maker_ff <= 8'h0;
      cnt_ff <= 20'h0;
      len_ff <= 20'h0;
      rd_start_ff <= 1'b0;
      rd_addr_ff <= 20'h0;
      TARGET_CMD <= 5'h0;
      LOAD_DATA <= 8'h0;
      LOAD_VALID <= 1'b0;
      ROM_SIZE <= `ROM_SZ_256K;
    end else begin
      host_req_d_ff <= host_req;
      rd_start_ff <= 1'b0;
      // sampled once after release; switch moves are ignored afterwards
      if (!latched_ff) begin
        latched_ff <= 1'b1;
        IF_PARALLEL_SEL <= if_sw; // R13 R15
        PAR_ECP_SEL <= if_sw & ecp_sw; // R14
      end
      case (st_ff)
        ST_IDLE: begin
          if (mode_press) begin
            mode_ff <= next_mode(mode_ff); // R2
          end else if (host_start || (enter_press && mode_ff == `MODE_LOAD)) begin
            run_ff <= `MODE_LOAD; // R7 R8
            err_ff <= 1'b0;
            sig_idx_ff <= 1'b0;
            rd_addr_ff <= 20'h0;
            rd_start_ff <= 1'b1;
            st_ff <= ST_SIG; // R10
          end else if (enter_press) begin
            err_ff <= 1'b0;
            if (cfg_ok) begin
              run_ff <= mode_ff; // R4
              TARGET_CMD <= mode_ff; // R6
              st_ff <= ST_RUN;
            end else begin
              // nothing stored to run with: stay idle, lamp steady
              err_ff <= 1'b1; // R6 R11
            end
          end
        end
        ST_RUN: begin
          if (tgt_done || tgt_fail) begin
            TARGET_CMD <= 5'h0;
            err_ff <= tgt_fail; // R11
            run_ff <= 5'h0;
            st_ff <= ST_IDLE;
          end
        end
        ST_SIG: begin
          if (rd_done) begin
            if (!sig_idx_ff) begin
              maker_ff <= rd_data;
              sig_idx_ff <= 1'b1;
              rd_addr_ff <= 20'h00001;
              rd_start_ff <= 1'b1;
            end else if (maker_ff == SIG_MAKER && (rd_data == SIG_PART_256K ||
                         rd_data == SIG_PART_512K || rd_data == SIG_PART_1M)) begin
              // top address lines only driven for the largest part
              ROM_SIZE <= (rd_data == SIG_PART_1M) ? `ROM_SZ_1M :
                          (rd_data == SIG_PART_512K) ? `ROM_SZ_512K : `ROM_SZ_256K; // R12
              len_ff <= LOAD_LEN;
              cnt_ff <= 20'h0;
              rd_addr_ff <= 20'h0;
              rd_start_ff <= 1'b1;
              st_ff <= ST_COPY;
            end else begin
              err_ff <= 1'b1; // R10 R11
              run_ff <= 5'h0;
              st_ff <= ST_IDLE;
            end
          end
        end
        ST_COPY: begin
          if (rd_done) begin
            LOAD_DATA <= rd_data;
            LOAD_VALID <= 1'b1;
            st_ff <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          if (ld_ack) begin
            LOAD_VALID <= 1'b0;
            st_ff <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!ld_ack) begin
            if (cnt_ff + 20'h1 >= len_ff) begin
              run_ff <= 5'h0;
              st_ff <= ST_IDLE;
            end else begin
              cnt_ff <= cnt_ff + 20'h1;
              rd_addr_ff <= cnt_ff + 20'h1;
              rd_start_ff <= 1'b1;
              st_ff <= ST_COPY;
            end
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // =====================================
  // lamps and rom pins
  always @(posedge MCLK) begin
    if (SRST) begin
      blink_cnt_ff <= 32'h0;
      blink_ff <= 1'b0;
      MODE_LAMP <= 5'h0;
      ACCESS_LAMP <= 1'b0;
      ERROR_LAMP <= 1'b0;
      ROM_ADDR <= 20'h0;
      ROM_CE_N <= 1'b1;
      ROM_OE_N <= 1'b1;
      BUSY <= 1'b0;
    end else begin
      if (blink_cnt_ff >= BLINK_CYC - 1) begin
        blink_cnt_ff <= 32'h0;
        blink_ff <= ~blink_ff;
      end else begin
        blink_cnt_ff <= blink_cnt_ff + 32'h1;
      end
      // one-hot mode gives one lamp; load mode lights load lamp alone
      MODE_LAMP <= (run_ff != 5'h0) ? (blink_ff ? run_ff : 5'h0) : mode_ff; // R3 R5 R7
      ACCESS_LAMP <= (st_ff == ST_SIG) || (st_ff == ST_COPY) ||
                     (st_ff == ST_PUSH) || (st_ff == ST_WAIT); // R9
      ERROR_LAMP <= err_ff; // R11
      ROM_ADDR <= (ROM_SIZE == `ROM_SZ_1M) ? rd_rom_addr :
                  {2'b00, rd_rom_addr[17:0]}; // R12
      ROM_CE_N <= rd_ce_n;
      ROM_OE_N <= rd_oe_n;
      BUSY <= (st_ff != ST_IDLE);
    end
  end
endmodule
`default_nettype wire

// >>> logic/sa_seq_consts.vh
`ifndef SA_SEQ_CONSTS_VH
`define SA_SEQ_CONSTS_VH
// =====================================
// mode one-hot codes
`define MODE_EPV 5'h01
`define MODE_ERASE 5'h02
`define MODE_PROG 5'h04
`define MODE_VERIFY 5'h08
`define MODE_LOAD 5'h10
// =====================================
// timing
`define CLK_MHZ 25
`define ROM_ACCESS_NS 200
`define ROM_ACCESS_CYC ((`ROM_ACCESS_NS * `CLK_MHZ + 999) / 1000)
`define BLINK_MS 250
`define BLINK_CYC (`BLINK_MS * 1000 * `CLK_MHZ)
`define DEBOUNCE_US 5000
`define DEBOUNCE_CYC (`DEBOUNCE_US * `CLK_MHZ)
// =====================================
// interface select codes
`define IF_SERIAL 1'b0
`define IF_PARALLEL 1'b1
// =====================================
// rom sizes, code on size pins
`define ROM_SZ_256K 2'h0
`define ROM_SZ_512K 2'h1
`define ROM_SZ_1M 2'h2
`define ROM_ADDR_W 20
`endif

// >>> logic/key_filter.v
`timescale 1ns/1ps
`default_nettype none
module key_filter #(
  parameter integer STABLE_CYC = 125000
) (
  input wire clk,
  input wire srst,
  input wire key_n,
  output reg press_ff
);
  // =====================================
  // synchroniser
  reg s1_ff;
  reg s2_ff;
  reg lvl_ff;
  reg [31:0] cnt_ff;
  always @(posedge clk) begin
    if (srst) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      lvl_ff <= 1'b1;
      cnt_ff <= 32'h0;
      press_ff <= 1'b0;
    end else begin
      s1_ff <= key_n;
      s2_ff <= s1_ff;
      press_ff <= 1'b0;
      // contact bounce would step the mode several times
      if (s2_ff == lvl_ff) begin
        cnt_ff <= 32'h0;
      end else if (cnt_ff >= STABLE_CYC - 1) begin
        cnt_ff <= 32'h0;
        lvl_ff <= s2_ff;
        press_ff <= ~s2_ff;
      end else begin
        cnt_ff <= cnt_ff + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> logic/rom_reader.v
`timescale 1ns/1ps
`default_nettype none
`include "sa_seq_consts.vh"
module rom_reader #(
  parameter integer WAIT_CYC = 5
) (
  input wire clk,
  input wire srst,
  input wire start,
  input wire [19:0] addr,
  input wire [7:0] rom_data_in,
  output reg [19:0] rom_addr_ff,
  output reg rom_ce_n_ff,
  output reg rom_oe_n_ff,
  output reg [7:0] data_ff,
  output reg done_ff
);
  reg [7:0] wait_ff;
  reg busy_ff;
  always @(posedge clk) begin
    if (srst) begin
      rom_addr_ff <= 20'h0;
      rom_ce_n_ff <= 1'b1;
      rom_oe_n_ff <= 1'b1;
      data_ff <= 8'h0;
      done_ff <= 1'b0;
      wait_ff <= 8'h0;
      busy_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (!busy_ff && start) begin
        rom_addr_ff <= addr; // R16
        rom_ce_n_ff <= 1'b0;
        rom_oe_n_ff <= 1'b0;
        wait_ff <= WAIT_CYC[7:0];
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        if (wait_ff == 8'h0) begin
          // data byte from pin sync stage: the pin level WAIT_CYC - 2 cycles after the rom pins are selected
          data_ff <= rom_data_in; // R16
          rom_ce_n_ff <= 1'b1;
          rom_oe_n_ff <= 1'b1;
          done_ff <= 1'b1;
          busy_ff <= 1'b0;
        end else begin
          wait_ff <= wait_ff - 8'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/sequencer_checks_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sequencer_checks (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic BUSY,
  input wire logic [4:0] MODE_LAMP,
  input wire logic [19:0] ROM_ADDR,
  input wire logic [1:0] ROM_SIZE,
  input wire logic ROM_CE_N,
  input wire logic ROM_OE_N,
  input wire logic ACCESS_LAMP,
  input wire logic IF_PARALLEL_SEL,
  input wire logic PAR_ECP_SEL,
  input wire logic LOAD_VALID,
  input wire logic LOAD_ACK,
  input wire logic [7:0] LOAD_DATA
);
  // =====
  // cycles since reset, latches settle by then
  logic [1:0] up_ff;
  always @(posedge MCLK) begin
    if (SRST) up_ff <= 2'h0;
    else if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);
  // =====
  // checks
  idle_onehot_a: assert property (up_ff == 2'h3 && !BUSY && !$past(BUSY) |-> $onehot(MODE_LAMP))
    else $error("idle mode lamp not one-hot");
  top_bits_a: assert property (ROM_SIZE != 2'h2 |-> ROM_ADDR[19:18] == 2'h0)
    else $error("top address lines used on small part");
  access_lamp_a: assert property (!ROM_CE_N |-> ACCESS_LAMP)
    else $error("rom selected with access lamp off");
  if_latch_a: assert property (up_ff == 2'h3 |-> $stable(IF_PARALLEL_SEL))
    else $error("interface select changed");
  ecp_latch_a: assert property (up_ff == 2'h3 |-> $stable(PAR_ECP_SEL))
    else $error("ecp select changed");
  gate_pair_a: assert property ($fell(ROM_CE_N) |-> !ROM_OE_N)
    else $error("output gate not with chip select");
  access_width_a: assert property ($fell(ROM_CE_N) |-> (!ROM_CE_N)[*5])
    else $error("rom access too short");
  valid_hold_a: assert property (LOAD_VALID && !LOAD_ACK |=> LOAD_VALID && $stable(LOAD_DATA))
    else $error("load byte dropped before ack");
endmodule
bind standalone_mode_sequencer sequencer_checks chk_i (.MCLK, .SRST, .BUSY, .MODE_LAMP,
  .ROM_ADDR, .ROM_SIZE, .ROM_CE_N, .ROM_OE_N, .ACCESS_LAMP, .IF_PARALLEL_SEL, .PAR_ECP_SEL,
  .LOAD_VALID, .LOAD_ACK, .LOAD_DATA);
`default_nettype wire

// >>> tb/rom_model.sv
`timescale 1ns/1ps
`default_nettype none
module rom_model (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic [19:0] addr,
  input wire logic [7:0] part,
  output logic [7:0] data
);
  // =====
  // byte-wide eprom, signature at 0 and 1
  // released bus inverts its last value on every input change, so a part change can bring back a stale byte
  initial data = 8'h00;
  always @(ce_n, oe_n, addr, part) begin
    if (!ce_n && !oe_n) data = addr == 20'h0 ? 8'h5a : addr == 20'h1 ? part : addr[7:0] ^ 8'hc3;
    else data = ~data;
  end
endmodule
`default_nettype wire

// >>> tb/test_standalone_mode_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_standalone_mode_sequencer;
  logic mclk = 0, srst = 1, mode_n = 1, enter_n = 1, if_sw = 1, ecp_sw = 1, host_req = 0;
  logic cfg_ok = 1, t_done = 0, t_fail = 0, ack = 0;
  logic [7:0] part = 8'h12;
  wire [7:0] rom_data, load_data;
  wire [4:0] lamp, tcmd;
  wire [19:0] rom_addr;
  wire [1:0] rom_size;
  wire acc, err, ifsel, ecpsel, ce_n, oe_n, lvalid, busy;
  integer fails = 0, checks_done = 0;
  initial forever #20 mclk = ~mclk;
  standalone_mode_sequencer #(.BLINK_CYC(4), .DEBOUNCE_CYC(2), .LOAD_LEN(20'h00004)) dut (
    .MCLK(mclk), .SRST(srst), .MODE_KEY_N(mode_n), .ENTER_KEY_N(enter_n), .IF_SELECT_SW(if_sw),
    .ECP_MODE_SW(ecp_sw), .HOST_LOAD_REQ(host_req), .CONFIG_VALID(cfg_ok), .TARGET_DONE(t_done),
    .TARGET_FAIL(t_fail), .LOAD_ACK(ack), .ROM_DATA(rom_data), .MODE_LAMP(lamp),
    .ACCESS_LAMP(acc), .ERROR_LAMP(err), .TARGET_CMD(tcmd), .IF_PARALLEL_SEL(ifsel),
    .PAR_ECP_SEL(ecpsel), .ROM_ADDR(rom_addr), .ROM_CE_N(ce_n), .ROM_OE_N(oe_n),
    .LOAD_DATA(load_data), .LOAD_VALID(lvalid), .ROM_SIZE(rom_size), .BUSY(busy));
  rom_model rom (.ce_n(ce_n), .oe_n(oe_n), .addr(rom_addr), .part(part), .data(rom_data));
  // =====
  // helpers
  task stop_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [19:0] got, input logic [19:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  // key held past the debounce window, then released
  task press(input logic m);
    @(negedge mclk);
    if (m) mode_n = 0;
    else enter_n = 0;
    repeat (8) @(negedge mclk);
    mode_n = 1;
    enter_n = 1;
    repeat (8) @(negedge mclk);
  endtask
  task wait_bit(input integer s, input logic v);
    integer i;
    for (i = 0; i < 3000 && (s ? lvalid : busy) !== v; i++) @(negedge mclk);
    if ((s ? lvalid : busy) !== v) begin
      fails++;
      $display("mismatch %0t hang", $time);
      stop_test;
    end
  endtask
  // =====
  // scenarios
  task mode_cycle;
    integer i;
    for (i = 1; i <= 5; i++) begin
      press(1);
      chk(lamp, 5'h01 << (i % 5), "mode step");
    end
  endtask
  task run_ok;
    integer i, off, on;
    off = 0;
    on = 0;
    press(0);
    chk(busy, 1, "enter starts");
    chk(tcmd, 5'h01, "command");
    for (i = 0; i < 16; i++) begin
      @(negedge mclk);
      if (lamp === 5'h00) off++;
      if (lamp === 5'h01) on++;
    end
    chk(off > 0 && on > 0, 1, "blink");
    t_done = 1;
    wait_bit(0, 0);
    t_done = 0;
    chk(err, 0, "no error");
    chk(lamp, 5'h01, "lamp back");
  endtask
  task run_bad;
    press(1);
    cfg_ok = 0;
    press(0);
    chk(err, 1, "no config");
    chk(busy, 0, "no run");
    chk(tcmd, 5'h00, "no command");
    chk(lamp, 5'h02, "lamp steady");
    cfg_ok = 1;
    press(0);
    chk(err, 0, "start clears");
    chk(tcmd, 5'h02, "erase command");
    t_fail = 1;
    wait_bit(0, 0);
    t_fail = 0;
    chk(err, 1, "fail lamp");
  endtask
  task load_run(input logic host, input logic [7:0] p, input logic [1:0] sz);
    integer i;
    part = p;
    if (host) begin
      host_req = 1;
      repeat (4) @(negedge mclk);
      host_req = 0;
    end else press(0);
    for (i = 0; i < 4; i++) begin
      wait_bit(1, 1);
      chk(load_data, i == 0 ? 8'h5a : i == 1 ? p : i ^ 8'hc3, "byte");
      chk(acc, 1, "access on");
      ack = 1;
      wait_bit(1, 0);
      ack = 0;
    end
    wait_bit(0, 0);
    chk(rom_size, sz, "size");
    chk(acc, 0, "access off");
    chk(err, 0, "load ok");
  endtask
  // second reset with the serial link chosen
  task reset_serial;
    @(negedge mclk);
    srst = 1;
    if_sw = 0;
    ecp_sw = 1;
    repeat (12) @(negedge mclk);
    srst = 0;
    repeat (3) @(negedge mclk);
    if_sw = 1;
    repeat (8) @(negedge mclk);
    chk(ifsel, 0, "serial latched");
    chk(ecpsel, 0, "no ecp on serial");
    chk(lamp, 5'h01, "mode after reset");
    chk(err, 0, "error cleared");
  endtask
  initial begin
    repeat (12) @(negedge mclk);
    srst = 0;
    repeat (3) @(negedge mclk);
    if_sw = 0;
    ecp_sw = 0;
    repeat (8) @(negedge mclk);
    chk(lamp, 5'h01, "power-on mode");
    chk(ifsel, 1, "if latched");
    chk(ecpsel, 1, "ecp latched");
    mode_cycle;
    run_ok;
    run_bad;
    repeat (3) press(1);
    load_run(0, 8'h12, 2'h1);
    load_run(1, 8'h13, 2'h2);
    part = 8'h77;
    host_req = 1;
    repeat (4) @(negedge mclk);
    host_req = 0;
    wait_bit(0, 0);
    chk(err, 1, "bad signature");
    reset_serial;
    stop_test;
  end
endmodule
`default_nettype wire
